// [wwdt_defines.vh]
// Constants shared by the windowed watchdog timer design files
`ifndef WWDT_DEFINES_VH
`define WWDT_DEFINES_VH

// Main control field layout: period select low, closed-window select high
`define WWDT_PER_LSB      0
`define WWDT_PER_MSB      3
`define WWDT_WIN_LSB      4
`define WWDT_WIN_MSB      7
`define WWDT_SEL_W        4
`define WWDT_CTL_W        8

// Value shown on main control before the fuse has been copied in
`define WWDT_CTL_RST      8'h00
// Selector code meaning "off" and the largest defined selector
`define WWDT_SEL_OFF      4'h0
`define WWDT_SEL_MAX      4'hB

// Watchdog tick rate and derived widths
`define WWDT_TICK_HZ      1024
`define WWDT_TICK_W       14
`define WWDT_CNT_W        15

// Period lengths in watchdog ticks, one per selector code
`define WWDT_TICKS_OFF    14'h0000
`define WWDT_TICKS_8      14'h0008
`define WWDT_TICKS_16     14'h0010
`define WWDT_TICKS_32     14'h0020
`define WWDT_TICKS_64     14'h0040
`define WWDT_TICKS_128    14'h0080
`define WWDT_TICKS_256    14'h0100
`define WWDT_TICKS_512    14'h0200
`define WWDT_TICKS_1K     14'h0400
`define WWDT_TICKS_2K     14'h0800
`define WWDT_TICKS_4K     14'h1000
`define WWDT_TICKS_8K     14'h2000

// Crossing into the tick domain completes on the tick after this age
`define WWDT_SYNC_W       2
`define WWDT_SYNC_LAST    2'h2

// Edges after reset before the edge detector holds two real pin samples
`define WWDT_WARM_W       2
`define WWDT_WARM_DONE    2'h3

`endif

// [wwdt_sync.v]
// Two-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ns
`default_nettype none

module wwdt_sync #(
    parameter WIDTH = 1
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;

    // First stage feeds only the second stage to keep metastability contained
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage_a;
            reg stage_b;
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    stage_a <= 1'b0;
                    stage_b <= 1'b0;
                end else begin
                    stage_a <= async_in[i];
                    stage_b <= stage_a;
                end
            end
            assign sync_out[i] = stage_b;
        end
    endgenerate

endmodule

`default_nettype wire

// [wwdt_period.v]
// Registered lookup from a period selector code to a length in watchdog ticks
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_defines.vh"

module wwdt_period (
    input  wire                    ref_clk,
    input  wire                    rst,
    input  wire [`WWDT_SEL_W-1:0]  sel,
    output reg  [`WWDT_TICK_W-1:0] ticks
);

    // Reserved codes above the table fall back to the longest period
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ticks <= `WWDT_TICKS_OFF;
        end else begin
            case (sel)
                4'h0:    ticks <= `WWDT_TICKS_OFF;
                4'h1:    ticks <= `WWDT_TICKS_8;
                4'h2:    ticks <= `WWDT_TICKS_16;
                4'h3:    ticks <= `WWDT_TICKS_32;
                4'h4:    ticks <= `WWDT_TICKS_64;
                4'h5:    ticks <= `WWDT_TICKS_128;
                4'h6:    ticks <= `WWDT_TICKS_256;
                4'h7:    ticks <= `WWDT_TICKS_512;
                4'h8:    ticks <= `WWDT_TICKS_1K;
                4'h9:    ticks <= `WWDT_TICKS_2K;
                4'hA:    ticks <= `WWDT_TICKS_4K;
                4'hB:    ticks <= `WWDT_TICKS_8K;
                default: ticks <= `WWDT_TICKS_8K;
            endcase
        end
    end

endmodule

`default_nettype wire

// [wwdt_top.v]
// Windowed watchdog timer: protected configuration, tick counting and reset request
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_defines.vh"

module wwdt_top (
    input  wire                   ref_clk,
    input  wire                   rst,
    input  wire                   low_power_osc,
    input  wire                   kick_instruction,
    input  wire                   change_protection_key,
    input  wire                   main_control_wr,
    input  wire [`WWDT_CTL_W-1:0] main_control_wdata,
    input  wire                   freeze_wr,
    input  wire                   freeze_wdata,
    input  wire                   debug_mode,
    input  wire [`WWDT_CTL_W-1:0] watchdog_fuse_config,
    input  wire                   reset_ack,
    output reg  [`WWDT_CTL_W-1:0] main_control,
    output reg                    freeze,
    output reg                    sync_pending,
    output reg                    watchdog_unit_enabled,
    output reg                    window_mode,
    output reg                    sys_reset_req
);

    // Tick recovery
    wire                    osc_sync;
    reg                     osc_prev;
    reg  [`WWDT_WARM_W-1:0] osc_warm;
    wire                    tick;

    // Configuration state
    reg                     booted;
    reg  [`WWDT_SEL_W-1:0]  period_act;
    reg  [`WWDT_SEL_W-1:0]  window_act;
    reg  [`WWDT_SYNC_W-1:0] ctl_age;
    wire                    ctl_accept;
    wire                    ctl_apply;
    wire                    boot_enable;

    // Counting state
    wire [`WWDT_TICK_W-1:0] open_ticks;
    wire [`WWDT_TICK_W-1:0] closed_ticks;
    reg  [`WWDT_CNT_W-1:0]  cnt;
    reg                     armed;
    reg                     kick_pend;
    reg  [`WWDT_SYNC_W-1:0] kick_age;
    wire [`WWDT_CNT_W-1:0]  cnt_inc;
    wire [`WWDT_CNT_W-1:0]  closed_ext;
    wire [`WWDT_CNT_W-1:0]  limit;
    wire                    kick_apply;
    wire                    kick_early;
    wire                    timeout;
    wire                    reset_event;

    // The oscillator output is a foreign clock, so it is only sampled here
    wwdt_sync #(
        .WIDTH    (1)
    ) u_osc_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (low_power_osc),
        .sync_out (osc_sync)
    );

    // Rising edge of the synchronised oscillator marks one watchdog tick;
    // edges are ignored until the history holds real pin samples, because the
    // synchroniser's reset values would otherwise fake a rise and shorten the first period
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_prev <= 1'b0;
            osc_warm <= {`WWDT_WARM_W{1'b0}};
        end else begin
            osc_prev <= osc_sync;
            if (osc_warm != `WWDT_WARM_DONE) begin
                osc_warm <= osc_warm + 2'h1;
            end
        end
    end

    assign tick = osc_sync & ~osc_prev & (osc_warm == `WWDT_WARM_DONE);

    // Period lengths follow the active selectors, not the pending register copy
    wwdt_period u_open_len (
        .ref_clk (ref_clk),
        .rst     (rst),
        .sel     (period_act),
        .ticks   (open_ticks)
    );

    wwdt_period u_closed_len (
        .ref_clk (ref_clk),
        .rst     (rst),
        .sel     (window_act),
        .ticks   (closed_ticks)
    );

    // A write lands only when keyed, unfrozen and no earlier write is in flight
    assign ctl_accept = main_control_wr & change_protection_key & ~freeze & ~sync_pending
                        & booted;

    // The pending copy reaches the counter on the third tick after the write
    assign ctl_apply = tick & sync_pending & (ctl_age == `WWDT_SYNC_LAST);

    // Fuse period decides whether the unit boots already running
    assign boot_enable = (watchdog_fuse_config[`WWDT_PER_MSB:`WWDT_PER_LSB]
                          != `WWDT_SEL_OFF);

    // Boot copy from fuse is taken after reset release, never under the async reset
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            booted                <= 1'b0;
            main_control          <= `WWDT_CTL_RST;
            freeze                <= 1'b0;
            sync_pending          <= 1'b0;
            ctl_age               <= {`WWDT_SYNC_W{1'b0}};
            period_act            <= `WWDT_SEL_OFF;
            window_act            <= `WWDT_SEL_OFF;
            watchdog_unit_enabled <= 1'b0;
            window_mode           <= 1'b0;
        end else if (!booted) begin
            booted                <= 1'b1;
            main_control          <= watchdog_fuse_config;
            period_act            <= watchdog_fuse_config[`WWDT_PER_MSB:`WWDT_PER_LSB];
            window_act            <= watchdog_fuse_config[`WWDT_WIN_MSB:`WWDT_WIN_LSB];
            watchdog_unit_enabled <= boot_enable;
            freeze                <= boot_enable;
            window_mode           <= (watchdog_fuse_config[`WWDT_WIN_MSB:`WWDT_WIN_LSB]
                                      != `WWDT_SEL_OFF);
        end else begin
            // Freeze: set from software when keyed, cleared only in debug
            if (freeze_wr && change_protection_key && freeze_wdata) begin
                freeze <= 1'b1;
            end else if (freeze_wr && change_protection_key && debug_mode) begin
                freeze <= 1'b0;
            end

            // Register copy is visible at once; the counter sees it after crossing
            if (ctl_accept) begin
                main_control <= main_control_wdata;
                sync_pending <= 1'b1;
                ctl_age      <= {`WWDT_SYNC_W{1'b0}};
            end else if (ctl_apply) begin
                sync_pending          <= 1'b0;
                period_act            <= main_control[`WWDT_PER_MSB:`WWDT_PER_LSB];
                window_act            <= main_control[`WWDT_WIN_MSB:`WWDT_WIN_LSB];
                watchdog_unit_enabled <= (main_control[`WWDT_PER_MSB:`WWDT_PER_LSB]
                                          != `WWDT_SEL_OFF);
                window_mode           <= (main_control[`WWDT_WIN_MSB:`WWDT_WIN_LSB]
                                          != `WWDT_SEL_OFF);
            end else if (tick && sync_pending) begin
                ctl_age <= ctl_age + 2'h1;
            end
        end
    end

    // Count and limit arithmetic, widened so the sum of two 8K periods fits
    assign cnt_inc    = cnt + 15'h0001;
    assign closed_ext = {1'b0, closed_ticks};
    assign limit      = (window_mode && armed) ? (closed_ext + {1'b0, open_ticks})
                                               : {1'b0, open_ticks};

    // Kick takes effect on the third tick after it, two to three ticks of delay
    assign kick_apply = tick & kick_pend & (kick_age == `WWDT_SYNC_LAST);

    // Too early: still inside the closed slot of an armed window
    assign kick_early = kick_apply & window_mode & armed & (cnt < closed_ext);

    // Too late: the count runs out before a kick was seen
    assign timeout = tick & watchdog_unit_enabled & (cnt_inc >= limit);

    assign reset_event = watchdog_unit_enabled & ~debug_mode & ~sys_reset_req
                         & (kick_early | (timeout & ~kick_apply));

    // Kick synchroniser: a kick in the applying cycle starts a fresh crossing
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            kick_pend <= 1'b0;
            kick_age  <= {`WWDT_SYNC_W{1'b0}};
        end else if (kick_instruction) begin
            kick_pend <= 1'b1;
            kick_age  <= {`WWDT_SYNC_W{1'b0}};
        end else if (kick_apply || (sys_reset_req && reset_ack)) begin
            kick_pend <= 1'b0;
            kick_age  <= {`WWDT_SYNC_W{1'b0}};
        end else if (tick && kick_pend) begin
            kick_age <= kick_age + 2'h1;
        end
    end

    // Counter: ticks from the pin keep it running whatever the CPU power state
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt   <= {`WWDT_CNT_W{1'b0}};
            armed <= 1'b0;
        end else if (debug_mode || ctl_apply || !watchdog_unit_enabled) begin
            // Halted CPU, new settings or a disabled unit restart the count;
            // the closed slot arms only after the next kick
            cnt   <= {`WWDT_CNT_W{1'b0}};
            armed <= 1'b0;
        end else if (sys_reset_req) begin
            cnt   <= {`WWDT_CNT_W{1'b0}};
            armed <= 1'b0;
        end else if (kick_apply) begin
            cnt   <= {`WWDT_CNT_W{1'b0}};
            armed <= window_mode;
        end else if (tick) begin
            cnt <= cnt_inc;
        end
    end

    // Reset request holds until acknowledged; a new event outranks the acknowledge
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sys_reset_req <= 1'b0;
        end else if (reset_event) begin
            sys_reset_req <= 1'b1;
        end else if (reset_ack) begin
            sys_reset_req <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// [wwdt_checker.sv]
// Port-level assertions for the windowed watchdog top module
`timescale 1ns/1ns
`default_nettype none
module wwdt_checker (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       low_power_osc,
    input wire logic       kick_instruction,
    input wire logic       change_protection_key,
    input wire logic       main_control_wr,
    input wire logic [7:0] main_control_wdata,
    input wire logic       freeze_wr,
    input wire logic       freeze_wdata,
    input wire logic       debug_mode,
    input wire logic [7:0] watchdog_fuse_config,
    input wire logic       reset_ack,
    input wire logic [7:0] main_control,
    input wire logic       freeze,
    input wire logic       sync_pending,
    input wire logic       watchdog_unit_enabled,
    input wire logic       window_mode,
    input wire logic       sys_reset_req
);
    reg  [1:0] age;
    reg  [2:0] pend_tk;
    reg        osc_q;
    wire       acc;
    // Edge age after release, and oscillator rises seen during a crossing
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            age     <= 2'h0;
            pend_tk <= 3'h0;
            osc_q   <= 1'b0;
        end else begin
            osc_q <= low_power_osc;
            age   <= (age == 2'h3) ? age : age + 2'h1;
            if (!sync_pending) begin
                pend_tk <= 3'h0;
            end else if (low_power_osc && !osc_q && pend_tk != 3'h7) begin
                pend_tk <= pend_tk + 3'h1;
            end
        end
    end
    // Writes on the very first edge are dropped while the fuse is copied in
    assign acc = main_control_wr && change_protection_key && !freeze && !sync_pending
                 && age != 2'h0;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    boot_load_a: assert property (age == 2'h0 |=> main_control == watchdog_fuse_config
        && freeze == (watchdog_fuse_config[3:0] != 4'h0)) else $error("Boot load wrong");
    write_take_a: assert property (acc |=> sync_pending
        && main_control == $past(main_control_wdata)) else $error("Write not taken");
    key_block_a: assert property (!change_protection_key && age != 2'h0
        |=> $stable(main_control) && $stable(freeze)) else $error("Keyless change");
    lock_hold_a: assert property (freeze && !debug_mode |=> freeze
        && $stable(main_control)) else $error("Lock not honoured");
    lock_set_a: assert property (freeze_wr && freeze_wdata && change_protection_key
        && age != 2'h0 |=> freeze) else $error("Lock not set");
    sync_len_a: assert property (pend_tk < 3'h4) else $error("Crossing too long");
    apply_mode_a: assert property ($fell(sync_pending) |->
        watchdog_unit_enabled == (main_control[3:0] != 4'h0)
        && window_mode == (main_control[7:4] != 4'h0)) else $error("Mode not applied");
    req_hold_a: assert property (sys_reset_req && !reset_ack |=> sys_reset_req)
        else $error("Request dropped early");
    req_drop_a: assert property (sys_reset_req && reset_ack |=> !sys_reset_req)
        else $error("Request kept after ack");
    off_quiet_a: assert property (!watchdog_unit_enabled && !$past(watchdog_unit_enabled)
        |-> !$rose(sys_reset_req)) else $error("Reset while off");
    cover property (acc);
    cover property ($rose(sys_reset_req));
    cover property ($rose(window_mode));
endmodule
bind wwdt_top wwdt_checker chk (.ref_clk(ref_clk), .rst(rst), .low_power_osc(low_power_osc),
    .kick_instruction(kick_instruction), .change_protection_key(change_protection_key),
    .main_control_wr(main_control_wr), .main_control_wdata(main_control_wdata),
    .freeze_wr(freeze_wr), .freeze_wdata(freeze_wdata), .debug_mode(debug_mode),
    .watchdog_fuse_config(watchdog_fuse_config), .reset_ack(reset_ack),
    .main_control(main_control), .freeze(freeze), .sync_pending(sync_pending),
    .watchdog_unit_enabled(watchdog_unit_enabled), .window_mode(window_mode),
    .sys_reset_req(sys_reset_req));
`default_nettype wire

// [wwdt_cpu_model.sv]
// Processor-side model: kick pulses and key-guarded register writes
`timescale 1ns/1ns
`default_nettype none
module wwdt_cpu_model (
    input  wire logic       ref_clk,
    output var  logic       kick_instruction,
    output var  logic       change_protection_key,
    output var  logic       main_control_wr,
    output var  logic [7:0] main_control_wdata,
    output var  logic       freeze_wr,
    output var  logic       freeze_wdata
);
    // Quiet bus until the first request
    initial begin
        kick_instruction      = 1'b0;
        change_protection_key = 1'b0;
        main_control_wr       = 1'b0;
        main_control_wdata    = 8'h00;
        freeze_wr             = 1'b0;
        freeze_wdata          = 1'b0;
    end
    // One-cycle request; data is inverted after release so stale values never look valid
    task automatic strobe(input logic c, input logic f, input logic k, input logic [7:0] d,
                          input logic key);
        @(posedge ref_clk);
        #1;
        change_protection_key = key;
        main_control_wr       = c;
        freeze_wr             = f;
        kick_instruction      = k;
        main_control_wdata    = d;
        freeze_wdata          = d[0];
        @(posedge ref_clk);
        #1;
        change_protection_key = 1'b0;
        main_control_wr       = 1'b0;
        freeze_wr             = 1'b0;
        kick_instruction      = 1'b0;
        main_control_wdata    = ~d;
        freeze_wdata          = ~d[0];
    endtask
endmodule
`default_nettype wire

// [windowed_watchdog_timer_test.sv]
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/1ns
`default_nettype none
module windowed_watchdog_timer_test;
    logic            ref_clk = 1'b0;
    logic            rst = 1'b1;
    logic            low_power_osc = 1'b0;
    logic            debug_mode = 1'b0;
    logic            reset_ack = 1'b0;
    logic [7:0]      fuse = 8'h00;
    logic [7:0]      m_ctl;
    logic            m_frz;
    logic            m_pend;
    wire logic       kick, key, cwr, fwr, fwd, pend, en, win, req, frz;
    wire logic [7:0] wdata, ctl;
    int              n_errors = 0;
    int              checks_done = 0;
    int              cyc = 0;
    int              exp_q[$];
    wwdt_top uut (.ref_clk(ref_clk), .rst(rst), .low_power_osc(low_power_osc),
        .kick_instruction(kick), .change_protection_key(key), .main_control_wr(cwr),
        .main_control_wdata(wdata), .freeze_wr(fwr), .freeze_wdata(fwd),
        .debug_mode(debug_mode), .watchdog_fuse_config(fuse), .reset_ack(reset_ack),
        .main_control(ctl), .freeze(frz), .sync_pending(pend),
        .watchdog_unit_enabled(en), .window_mode(win), .sys_reset_req(req));
    wwdt_cpu_model cpu (.ref_clk(ref_clk), .kick_instruction(kick),
        .change_protection_key(key), .main_control_wr(cwr), .main_control_wdata(wdata),
        .freeze_wr(fwr), .freeze_wdata(fwd));
    // 250 MHz system clock
    always #2 ref_clk = ~ref_clk;
    // Fast watchdog oscillator, 16 system cycles a period, phase off the system clock
    initial begin
        #5;
        forever #32 low_power_osc = ~low_power_osc;
    end
    // Hang guard well above the expected run length
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            $display("ERROR at %0t: run hung", $time);
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Period length in ticks for a selector; codes above eleven act as the longest
    function automatic int per_ticks(input int sel);
        return 8 << ((sel > 11 ? 11 : sel) - 1);
    endfunction
    task automatic boot(input logic [7:0] f);
        rst = 1'b1;
        fuse = f;
        repeat (12) @(posedge ref_clk);
        #1 rst = 1'b0;
        @(posedge ref_clk);
        #1;
        m_ctl = f;
        m_frz = (f[3:0] != 4'h0);
        m_pend = 1'b0;
        check(ctl, f);
        check(frz, m_frz);
        check(en, m_frz);
        check(win, f[7:4] != 4'h0);
    endtask
    task automatic do_ctl(input logic [7:0] d, input logic k);
        if (k && !m_frz && !m_pend) begin
            m_ctl = d;
            m_pend = 1'b1;
        end
        cpu.strobe(1'b1, 1'b0, 1'b0, d, k);
        check(ctl, m_ctl);
        check(pend, m_pend);
    endtask
    task automatic do_frz(input logic d, input logic k);
        if (k && (d || debug_mode)) m_frz = d;
        cpu.strobe(1'b0, 1'b1, 1'b0, {7'h00, d}, k);
        check(frz, m_frz);
    endtask
    task automatic wait_sync();
        for (int i = 0; i < 200 && pend !== 1'b0; i++) @(posedge ref_clk);
        #1;
        m_pend = 1'b0;
        check(pend, 1'b0);
        check(en, m_ctl[3:0] != 4'h0);
        check(win, m_ctl[7:4] != 4'h0);
    endtask
    // Kick in mid-period so the next three oscillator rises carry it across
    task automatic mid_kick();
        @(negedge low_power_osc);
        cpu.strobe(1'b0, 1'b0, 1'b1, 8'h00, 1'b0);
    endtask
    task automatic ticks_to_req(output int n);
        logic q;
        n = 0;
        q = low_power_osc;
        repeat (6000) begin
            @(posedge ref_clk);
            if (req === 1'b1) break;
            if (low_power_osc && !q) n++;
            q = low_power_osc;
        end
    endtask
    task automatic ack();
        @(posedge ref_clk);
        #1 reset_ack = 1'b1;
        @(posedge ref_clk);
        #1 reset_ack = 1'b0;
        check(req, 1'b0);
    endtask
    // Early run kicks just after arming; late run kicks once in the open slot then stops
    task automatic win_run(input logic early);
        int n;
        do_ctl(8'h11, 1'b1);
        wait_sync();
        mid_kick();
        repeat (early ? 3 : 10) @(posedge low_power_osc);
        mid_kick();
        ticks_to_req(n);
        check(n, early ? 3 : 19);
        ack();
    endtask
    initial begin
        int n;
        void'($urandom(19));
        boot(8'h00);
        do_ctl(8'($urandom), 1'b0);
        do_frz(1'b1, 1'b0);
        do_frz(1'b1, 1'b1);
        do_ctl(8'h05, 1'b1);
        do_frz(1'b0, 1'b1);
        debug_mode = 1'b1;
        do_frz(1'b0, 1'b1);
        debug_mode = 1'b0;
        for (int s = 1; s <= 6; s++) begin
            do_ctl({4'h0, s[3:0]}, 1'b1);
            exp_q.push_back(per_ticks(s));
            do_ctl(8'($urandom), 1'b1);
            wait_sync();
            ticks_to_req(n);
            check(n, exp_q.pop_front());
            ack();
        end
        do_ctl(8'h02, 1'b1);
        wait_sync();
        repeat (4) begin
            repeat (10) @(posedge low_power_osc);
            mid_kick();
        end
        check(req, 1'b0);
        ticks_to_req(n);
        check(n, 19);
        ack();
        win_run(1'b1);
        win_run(1'b0);
        boot({4'($urandom), 4'($urandom % 11 + 1)});
        do_ctl(8'h00, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
